// file: hw/pd_ctrl_end.sv
// Controller-side power-down sequencer with AHB-Lite registers
`timescale 1ns/1ps
// Notes on behaviour
// - NOP exit needs parity, latency, gear-down off
// - Only NOP inside post-exit multiplexed window
// - Entry when clock-enable low with deselect
// - No entry during register, calibration, data ops
// - Row, precharge, refresh may finish after entry
// - Reset DLL after exit if unlocked
// - Precharge or active power-down by open banks
// - Buffers off except clock, enable, reset
// - Config bit selects ODT buffer on or off
// - Park termination kept when enabled
// - Deselects throughout pass-disable delay
// - DLL stays on in power-down
// - Hold enable low, reset high, ODT valid
// - Reset low leaves power-down into reset
// - Enable level held minimum pulse time
// - Stay bounded to nine refresh intervals
// - Exit when enable high with deselect
// - ODT valid at exit if nominal on
// - Minimum power-down time before exit
// - ODT steady around entry when buffer disabled
// - ODT may float after pass-disable delay
module pd_ctrl_end #(
  parameter int unsigned PD_MAX = pd_pkg::PD_MAX_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  pd_link_if.ctrl LINK,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic BUSY_NOSTOP,
  input wire logic [2:0] USER_CMD,
  input wire logic [3:0] USER_BANK,
  input wire logic USER_ODT
);
  initial begin
    if (PD_MAX < 8) $error("PD_MAX too small");
  end
  localparam int unsigned CW = $clog2(PD_MAX + 1);
  localparam int unsigned PREP = pd_pkg::DODT_OFF_NCK + 1;
  pd_pkg::host_state_t st_ff;
  logic [CW-1:0] cnt_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] cfg_ff;
  logic ap_wr_ff;
  logic ap_rd_ff;
  logic [31:0] ap_addr_ff;
  logic odt_hold_ff;
  logic ap;
  logic pd_req;
  logic odt_float_ok;
  assign ap = HSEL && HREADY && HTRANS[1];
  assign pd_req = ctrl_ff[0];
  // cfg[0]: ODT buffer-disable mode, cfg[1]: nominal termination on
  assign odt_float_ok = cfg_ff[0] && !cfg_ff[1];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ap_wr_ff <= 1'b0;
      ap_rd_ff <= 1'b0;
      ap_addr_ff <= 32'h0000_0000;
    end else begin
      ap_wr_ff <= ap && HWRITE;
      ap_rd_ff <= ap && !HWRITE;
      ap_addr_ff <= HADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_ff <= 32'h0000_0000;
      cfg_ff <= 32'h0000_0000;
    end else if (ap_wr_ff) begin
      if (ap_addr_ff == pd_pkg::AHB_OFF_CTRL) begin
        ctrl_ff <= {31'h0, HWDATA[0]};
      end else if (ap_addr_ff == pd_pkg::AHB_OFF_CFG) begin
        cfg_ff <= {30'h0, HWDATA[1:0]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (ap && !HWRITE) begin
      unique case (HADDR)
        pd_pkg::AHB_OFF_CTRL: HRDATA <= ctrl_ff;
        pd_pkg::AHB_OFF_STAT: HRDATA <= {29'h0, st_ff};
        pd_pkg::AHB_OFF_CFG: HRDATA <= cfg_ff;
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_ff <= pd_pkg::HS_RUN;
      cnt_ff <= '0;
    end else begin
      unique case (st_ff)
        pd_pkg::HS_RUN: begin
          if (pd_req && !BUSY_NOSTOP) begin
            st_ff <= pd_pkg::HS_PREP;
            cnt_ff <= CW'(PREP);
          end
        end
        pd_pkg::HS_PREP: begin
          if (cnt_ff == '0) begin
            st_ff <= pd_pkg::HS_DOWN;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        pd_pkg::HS_DOWN: begin
          // Min stay covers tCKE, tPD and tCPDED; max bounds refresh
          if ((!pd_req && cnt_ff >= CW'(pd_pkg::CKE_MIN_CYC) &&
              cnt_ff >= CW'(pd_pkg::CPDED_NCK)) ||
              cnt_ff == CW'(PD_MAX - 1)) begin
            st_ff <= pd_pkg::HS_EXIT;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        pd_pkg::HS_EXIT: begin
          st_ff <= pd_pkg::HS_XP;
          cnt_ff <= '0;
        end
        pd_pkg::HS_XP: begin
          if (cnt_ff >= CW'(pd_pkg::XP_CYC) &&
              cnt_ff >= CW'(pd_pkg::CKE_MIN_CYC)) begin
            st_ff <= pd_pkg::HS_RUN;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: st_ff <= pd_pkg::HS_RUN;
      endcase
    end
  end

  // ODT level frozen from prep through the pass-disable delay
  always_ff @(posedge CLK) begin
    if (SRST) begin
      odt_hold_ff <= 1'b0;
    end else if (st_ff == pd_pkg::HS_RUN) begin
      odt_hold_ff <= USER_ODT;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.cke <= 1'b1;
      LINK.reset_n <= 1'b1;
      LINK.cmd <= pd_pkg::CMD_DES;
      LINK.bank <= 4'h0;
      LINK.odt <= 1'b0;
      LINK.odt_oe <= 1'b1;
    end else begin
      LINK.reset_n <= 1'b1;
      LINK.cke <= !(st_ff == pd_pkg::HS_DOWN);
      LINK.bank <= USER_BANK;
      // Only user commands in run; never NOP so no mux window arises
      LINK.cmd <= (st_ff == pd_pkg::HS_RUN && !pd_req &&
        USER_CMD != 3'(pd_pkg::CMD_NOP)) ?
        pd_pkg::cmd_t'(USER_CMD) : pd_pkg::CMD_DES;
      LINK.odt <= (st_ff == pd_pkg::HS_RUN) ? USER_ODT : odt_hold_ff;
      LINK.odt_oe <= !(st_ff == pd_pkg::HS_DOWN && odt_float_ok &&
        cnt_ff >= CW'(pd_pkg::CPDED_NCK));
    end
  end
endmodule

// file: hw/pd_pkg.sv
// Shared constants and types for the power-down link
package pd_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned CPDED_NCK = 4;
  localparam int unsigned CKE_MIN_NS = 5;
  localparam int unsigned CKE_MIN_CYC =
    (CKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XP_NS = 6;
  localparam int unsigned XP_CYC =
    (XP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REFI_NS = 7800;
  localparam int unsigned PD_MAX_REFI = 9;
  localparam int unsigned PD_MAX_CYC =
    (PD_MAX_REFI * REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DODT_OFF_NCK = 2;
  localparam int unsigned WL_NCK = 9;
  localparam int unsigned ANPD_NCK = WL_NCK - 1;
  localparam int unsigned MR5_ODTBUF_BIT = 5;
  localparam int unsigned MR5_PARK_LSB = 6;
  localparam int unsigned BANKS = 16;
  localparam int unsigned BUSY_MAX = 16;
  localparam logic [2:0] PARK_OFF = 3'h0;
  localparam logic [2:0] NOM_OFF = 3'h0;
  localparam logic [31:0] AHB_OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] AHB_OFF_STAT = 32'h0000_0004;
  localparam logic [31:0] AHB_OFF_CFG = 32'h0000_0008;

  // Command encodings on the shared bus
  typedef enum logic [2:0] {
    CMD_DES = 3'h0,
    CMD_NOP = 3'h1,
    CMD_ACT = 3'h2,
    CMD_PRE = 3'h3,
    CMD_REF = 3'h4,
    CMD_RD = 3'h5,
    CMD_WR = 3'h6,
    CMD_MRS = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    PD_RUN = 2'h0,
    PD_ENTER = 2'h1,
    PD_DOWN = 2'h2
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_RUN = 3'h0,
    HS_PREP = 3'h1,
    HS_DOWN = 3'h2,
    HS_EXIT = 3'h3,
    HS_XP = 3'h4
  } host_state_t;
endpackage

// file: hw/pd_link_if.sv
// Interface joining controller and memory power-down ends
`timescale 1ns/1ps
interface pd_link_if;
  logic cke;
  logic reset_n;
  pd_pkg::cmd_t cmd;
  logic [3:0] bank;
  logic odt;
  logic odt_oe;
  modport ctrl (output cke, output reset_n, output cmd, output bank,
    output odt, output odt_oe);
  modport mem (input cke, input reset_n, input cmd, input bank,
    input odt, input odt_oe);
endinterface

// file: hw/pd_mem_end.sv
// Memory-side power-down entry, exit and buffer control
`timescale 1ns/1ps
module pd_mem_end #(
  parameter int unsigned BANK_CNT = pd_pkg::BANKS
) (
  input wire logic CLK,
  input wire logic SRST,
  pd_link_if.mem LINK,
  input wire logic [8:0] MR5,
  input wire logic [2:0] MR1_NOM,
  input wire logic BG_BUSY,
  output logic PD_ACTIVE,
  output logic PD_PRECHARGE,
  output logic IO_BUF_ON,
  output logic CA_RX_ON,
  output logic ODT_BUF_ON,
  output logic TERM_NOM,
  output logic TERM_PARK,
  output logic DLL_ON
);
  initial begin
    if (BANK_CNT != 16) $error("BANK_CNT must be 16");
  end
  pd_pkg::dev_state_t st_ff;
  logic [BANK_CNT-1:0] open_ff;
  logic [2:0] cpd_ff;
  logic dn;
  logic odtbuf_dis;
  logic park_en;
  logic nom_en;
  logic rst;
  assign rst = SRST || !LINK.reset_n;
  assign dn = (st_ff != pd_pkg::PD_RUN);
  assign odtbuf_dis = MR5[pd_pkg::MR5_ODTBUF_BIT];
  assign park_en = MR5[pd_pkg::MR5_PARK_LSB +: 3] != pd_pkg::PARK_OFF;
  assign nom_en = MR1_NOM != pd_pkg::NOM_OFF;

  always_ff @(posedge CLK) begin
    if (rst) begin
      st_ff <= pd_pkg::PD_RUN;
    end else begin
      unique case (st_ff)
        pd_pkg::PD_RUN: begin
          if (!LINK.cke && LINK.cmd == pd_pkg::CMD_DES) begin
            st_ff <= pd_pkg::PD_ENTER;
          end
        end
        pd_pkg::PD_ENTER, pd_pkg::PD_DOWN: begin
          if (LINK.cke && LINK.cmd == pd_pkg::CMD_DES) begin
            st_ff <= pd_pkg::PD_RUN;
          end else if (st_ff == pd_pkg::PD_ENTER && !BG_BUSY) begin
            st_ff <= pd_pkg::PD_DOWN;
          end
        end
        default: st_ff <= pd_pkg::PD_RUN;
      endcase
    end
  end

  // Bank tracking only while receivers are live
  always_ff @(posedge CLK) begin
    if (rst) begin
      open_ff <= '0;
    end else if (CA_RX_ON) begin
      if (LINK.cmd == pd_pkg::CMD_ACT) begin
        open_ff[LINK.bank] <= 1'b1;
      end else if (LINK.cmd == pd_pkg::CMD_PRE) begin
        open_ff[LINK.bank] <= 1'b0;
      end
    end
  end

  // Receivers stay on for the pass-disable delay after entry
  always_ff @(posedge CLK) begin
    if (rst || !dn) begin
      cpd_ff <= 3'(pd_pkg::CPDED_NCK);
    end else if (cpd_ff != 3'h0) begin
      cpd_ff <= cpd_ff - 3'h1;
    end
  end

  assign CA_RX_ON = !dn || cpd_ff != 3'h0;
  assign PD_ACTIVE = st_ff == pd_pkg::PD_DOWN && |open_ff;
  assign PD_PRECHARGE = st_ff == pd_pkg::PD_DOWN && !(|open_ff);
  assign IO_BUF_ON = !dn;
  assign ODT_BUF_ON = !dn || !odtbuf_dis;
  // Sampled ODT near entry may give nominal or park
  assign TERM_NOM = nom_en && LINK.odt && ODT_BUF_ON &&
    (!dn || cpd_ff != 3'h0 || !odtbuf_dis);
  assign TERM_PARK = park_en && !TERM_NOM;
  assign DLL_ON = 1'b1;
endmodule

// file: dv/pd_link_chk.sv
// Assertions on the power-down link between the two ends
`timescale 1ns/1ps
module pd_link_chk #(
  parameter int unsigned PD_MAX = pd_pkg::PD_MAX_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic cke,
  input wire logic reset_n,
  input wire pd_pkg::cmd_t cmd,
  input wire logic [3:0] bank,
  input wire logic odt,
  input wire logic odt_oe
);
  logic [15:0] low_cnt_ff;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // Length of the current low stretch of cke
  always_ff @(posedge CLK) begin
    if (SRST || cke)
      low_cnt_ff <= 16'h0000;
    else
      low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  property p_fall_des;
    $fell(cke) |-> cmd == pd_pkg::CMD_DES;
  endproperty
  a_fall_des: assert property (p_fall_des)
    else $error("cke fell without deselect");
  property p_des_cpded;
    $fell(cke) |-> (cmd == pd_pkg::CMD_DES && !cke)[*4];
  endproperty
  a_des_cpded: assert property (p_des_cpded)
    else $error("no deselect or cke high in entry delay");
  property p_rise_des;
    $rose(cke) |-> cmd == pd_pkg::CMD_DES ##1 cke;
  endproperty
  a_rise_des: assert property (p_rise_des)
    else $error("bad cke rise");
  property p_low_min;
    $rose(cke) |-> low_cnt_ff >= 16'h0004;
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("power-down stay too short");
  property p_low_max;
    low_cnt_ff <= PD_MAX;
  endproperty
  a_low_max: assert property (p_low_max)
    else $error("power-down stay too long");
  property p_rst_hold;
    !cke |-> reset_n;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset asserted in power-down");
  property p_odt_pre;
    $fell(cke) |-> odt_oe && odt == $past(odt, 3);
  endproperty
  a_odt_pre: assert property (p_odt_pre)
    else $error("odt moved before entry");
  property p_odt_post;
    $fell(cke) |=> ($stable(odt) && odt_oe)[*3];
  endproperty
  a_odt_post: assert property (p_odt_post)
    else $error("odt moved in entry delay");
  c_fall: cover property ($fell(cke));
  c_rise: cover property ($rose(cke));
  c_max: cover property (low_cnt_ff == PD_MAX);
endmodule

// file: dv/tb.sv
// Self-checking bench for both ends of the power-down link
`timescale 1ns/1ps
module tb;
  localparam int unsigned PD_MAX = 64;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hro;
  logic hresp;
  logic busy = 1'b0;
  logic [2:0] ucmd = 3'h0;
  logic [3:0] ubank = 4'h0;
  logic uodt = 1'b0;
  logic [8:0] mr5 = 9'h060;
  logic [2:0] mr1 = 3'h1;
  logic bg = 1'b0;
  logic pda, pdp, iob, carx, odtb, tnom, tpark, dll;
  int failures = 0;
  int check_count = 0;
  int n;
  always #4 clk = ~clk;
  pd_link_if u_pd_link_if();
  pd_ctrl_end #(.PD_MAX(PD_MAX)) u_pd_ctrl_end (.CLK(clk), .SRST(srst),
    .LINK(u_pd_link_if), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro),
    .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp),
    .BUSY_NOSTOP(busy), .USER_CMD(ucmd), .USER_BANK(ubank),
    .USER_ODT(uodt));
  pd_mem_end u_pd_mem_end (.CLK(clk), .SRST(srst), .LINK(u_pd_link_if),
    .MR5(mr5), .MR1_NOM(mr1), .BG_BUSY(bg), .PD_ACTIVE(pda),
    .PD_PRECHARGE(pdp), .IO_BUF_ON(iob), .CA_RX_ON(carx),
    .ODT_BUF_ON(odtb), .TERM_NOM(tnom), .TERM_PARK(tpark), .DLL_ON(dll));
  pd_link_chk #(.PD_MAX(PD_MAX)) u_pd_link_chk (.CLK(clk), .SRST(srst),
    .cke(u_pd_link_if.cke), .reset_n(u_pd_link_if.reset_n),
    .cmd(u_pd_link_if.cmd), .bank(u_pd_link_if.bank),
    .odt(u_pd_link_if.odt), .odt_oe(u_pd_link_if.odt_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Address phase, then data phase; each held until hready is seen
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hro !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hro !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic wait_cke(input logic v);
    do @(posedge clk); while (u_pd_link_if.cke !== v);
  endtask
  function automatic logic [31:0] flags();
    return 32'({pda, pdp, iob, carx, odtb, tnom, tpark, dll});
  endfunction
  task automatic test_done();
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wr(pd_pkg::AHB_OFF_CFG, 32'h3);
    rdc(pd_pkg::AHB_OFF_CFG, 32'h3);
    rdc(32'h0000_0010, 32'h0);
    busy <= 1'b1;
    wr(pd_pkg::AHB_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk(32'(u_pd_link_if.cke), 32'h1);
    busy <= 1'b0;
    wait_cke(1'b0);
    repeat (3) @(posedge clk);
    #1 chk(32'(carx), 32'h1);
    @(posedge clk);
    #1 chk(32'(carx), 32'h0);
    ucmd <= 3'h2;
    repeat (4) @(posedge clk);
    chk(32'(u_pd_link_if.cmd), 32'h0);
    chk(flags(), 32'h43);
    rdc(pd_pkg::AHB_OFF_STAT, 32'h2);
    ucmd <= 3'h0;
    wr(pd_pkg::AHB_OFF_CTRL, 32'h0);
    wait_cke(1'b1);
    repeat (8) @(posedge clk);
    chk(flags(), 32'h3B);
    rdc(pd_pkg::AHB_OFF_STAT, 32'h0);
    // Open a bank so the next stay is active power-down
    mr5 <= 9'h040;
    wr(pd_pkg::AHB_OFF_CFG, 32'h2);
    ucmd <= 3'h2;
    ubank <= 4'h3;
    @(posedge clk);
    ucmd <= 3'h0;
    repeat (4) @(posedge clk);
    bg <= 1'b1;
    wr(pd_pkg::AHB_OFF_CTRL, 32'h1);
    wait_cke(1'b0);
    repeat (8) @(posedge clk);
    #1 chk(32'(pda), 32'h0);
    bg <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(flags(), 32'h8B);
    n = 0;
    while (u_pd_link_if.cke === 1'b0 && n < PD_MAX + 8) begin
      @(posedge clk);
      n++;
    end
    chk(32'(u_pd_link_if.cke), 32'h1);
    wr(pd_pkg::AHB_OFF_CTRL, 32'h0);
    test_done();
  end
  // The sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
